// ### bpt_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module bpt_asserts #(
  parameter int MAX_FRAME = 21100
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // watched signals
  input wire logic line,
  input wire logic busy_o,
  input wire logic imu_valid_i,
  input wire logic is_modem_i,
  input wire logic raw_imu_en_i,
  input wire logic imu_fwd_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pkt_ok_o,
  input wire logic pkt_bad_o
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  logic [15:0] busy_cnt_reg;
  // longest frame is 260 bytes; a stuck busy would otherwise go unseen
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_cnt_reg <= 16'h0000;
    end else begin
      busy_cnt_reg <= busy_o ? busy_cnt_reg + 16'h0001 : 16'h0000;
    end
  end
  // repetition counts assume 8 clocks per bit, as the bench sets
  a_idle_line_high: assert property (!busy_o |-> line)
    else $error("line low while idle");
  a_imu_takes_busy: assert property (imu_valid_i &&
    (is_modem_i ? imu_fwd_en_i : raw_imu_en_i) |-> ##[1:2] busy_o)
    else $error("sample not taken");
  a_start_after_busy: assert property ($rose(busy_o) |=> !line)
    else $error("no start bit after busy");
  a_zero_bit_width: assert property ($fell(line) |-> !line [*8])
    else $error("low bit too short");
  a_high_bit_width: assert property ($rose(line) |-> line [*8])
    else $error("high bit too short");
  a_frame_bounded: assert property (busy_cnt_reg <= MAX_FRAME)
    else $error("frame too long");
  a_pready_second: assert property (psel_i && !penable_i ##1 psel_i && penable_i |=> pready_o)
    else $error("apb answer late");
  a_pready_single: assert property (pready_o |=> !pready_o)
    else $error("pready held");
  a_verdict_pulse: assert property (pkt_ok_o || pkt_bad_o |->
    !(pkt_ok_o && pkt_bad_o) ##1 !(pkt_ok_o || pkt_bad_o)) else $error("bad verdict pulse");
  a_verdict_at_stop: assert property (pkt_ok_o || pkt_bad_o |-> line && $past(line))
    else $error("verdict before stop bit");
  c_frame: cover property ($rose(busy_o));
  c_good: cover property (pkt_ok_o);
  c_apb: cover property (psel_i && penable_i && pready_o);
endmodule
`default_nettype wire

// ### bpt_cfg.svh
`ifndef BPT_CFG_SVH
`define BPT_CFG_SVH
// ----------------------------------------
// frame constants
// ----------------------------------------
`define BPT_ADDR_BYTE 8'hff
`define BPT_TYPE_BYTE 8'h47
`define BPT_CODE_CM 16'h0002
`define BPT_CODE_MM 16'h0012
`define BPT_CODE_IMU 16'h0003
`define BPT_HDR_LEN 9'h005
`define BPT_REC_START 9'h006
`define BPT_REC_CM 4'h8
`define BPT_REC_MM 4'he
`define BPT_MM_FLAG_POS 4'hd
`define BPT_IMU_LEN 8'h20
`define BPT_IMU_ADDR_POS 5'h12
`define BPT_IMU_TS_POS 5'h18
`define BPT_IMU_FLAG_POS 5'h1c
`define BPT_MAX_BCN 18
// ----------------------------------------
// crc and timing
// ----------------------------------------
`define BPT_CRC_POLY 16'ha001
`define BPT_CRC_INIT 16'hffff
`define BPT_CLK_HZ 40000000
`define BPT_RESEND_S 10
`define BPT_BAUD 115200
`define BPT_CLKS_PER_BIT (`BPT_CLK_HZ / `BPT_BAUD)
// ----------------------------------------
// controller register map
// ----------------------------------------
`define BPT_REG_CTRL 12'h000
`define BPT_REG_STATUS 12'h004
`define BPT_REG_COUNT 12'h008
`define BPT_REG_NA 12'h00c
`define BPT_REG_BUF 12'h100
`define BPT_BUF_BYTES 64
`define BPT_CTRL_EN 0
`define BPT_CTRL_CLR 1
`endif

// ### bpt_dev.sv
// Summary of operation
// - send position list on freeze, resend 10 s
// - header ff, 47, then 16-bit data code
// - length byte at 4, 1+8N or 1+14N
// - beacon count at 5, then N records
// - centimetre list uses data code 0x0002
// - cm record: addr, x, y, z, zero
// - mm list code 0x0012, 14-byte records
// - mm flag bit 0 marks beacon ignored
// - crc follows payload directly
// - inertial packet code 0x0003 per sample
// - beacon unit: 100 Hz when raw enabled
// - modem unit: forward when option enabled
// - inertial payload exactly 32 bytes
// - accelerometer words at 0, 2, 4
// - gyroscope words at 6, 8, 10
// - magnetometer words at 12, 14, 16
// - address at 18, timestamp at 24
// - flags at 28, unavailable sensors set
`timescale 1ns/1ps
`default_nettype none
`include "bpt_cfg.svh"
module bpt_dev #(
  parameter int CLKS_PER_BIT = `BPT_CLKS_PER_BIT,
  parameter int RESEND_CYC = `BPT_RESEND_S * `BPT_CLK_HZ,
  parameter int MAX_BCN = `BPT_MAX_BCN
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // serial link
  bpt_link_if.dev link,
  // beacon map
  input wire logic map_frozen_i,
  input wire logic mm_mode_i,
  input wire logic [4:0] bcn_count_i,
  output logic [4:0] bcn_sel_o,
  input wire logic [7:0] bcn_addr_i,
  input wire logic [31:0] bcn_x_i,
  input wire logic [31:0] bcn_y_i,
  input wire logic [31:0] bcn_z_i,
  input wire logic bcn_na_i,
  // inertial samples
  input wire logic is_modem_i,
  input wire logic raw_imu_en_i,
  input wire logic imu_fwd_en_i,
  input wire logic imu_valid_i,
  input wire logic [8:0][15:0] imu_word_i,
  input wire logic [7:0] imu_addr_i,
  input wire logic [31:0] imu_ts_i,
  input wire logic [2:0] imu_na_i,
  // status
  output logic busy_o
);
  typedef struct packed {
    bpt_pkg::bpt_tx_st_t st;
    bpt_pkg::bpt_kind_t kind;
    logic [8:0] bidx;
    logic [4:0] rec;
    logic [3:0] rb;
    logic [4:0] nb;
    logic [15:0] crc;
    logic [8:0] shreg;
    logic [3:0] bitcnt;
    logic [15:0] baud;
    logic [31:0] timer;
    logic frozen_d;
    logic pos_pend;
    logic imu_pend;
    logic [8:0][15:0] iw;
    logic [7:0] iaddr;
    logic [31:0] its;
    logic [2:0] ina;
    logic txd;
    logic busy;
  } dev_state_t;

  dev_state_t s_reg, s_next;
  logic [7:0] len;
  logic [8:0] crc_pos;
  logic [3:0] rec_len;
  logic [15:0] code;
  logic [7:0] cur;
  logic [4:0] p;
  logic imu_ok;

  // ----------------------------------------
  // byte selection
  // ----------------------------------------
  always_comb begin
    rec_len = (s_reg.kind == bpt_pkg::KIND_MM) ? `BPT_REC_MM : `BPT_REC_CM;
    case (s_reg.kind)
      bpt_pkg::KIND_CM: code = `BPT_CODE_CM;
      bpt_pkg::KIND_MM: code = `BPT_CODE_MM;
      default: code = `BPT_CODE_IMU;
    endcase
    if (s_reg.kind == bpt_pkg::KIND_IMU) begin
      len = `BPT_IMU_LEN;
    end else begin
      len = 8'(1 + s_reg.nb * rec_len);
    end
    crc_pos = 9'(`BPT_HDR_LEN + len);
    p = 5'(s_reg.bidx - `BPT_HDR_LEN);
    cur = 8'h00;
    case (s_reg.bidx)
      9'h000: cur = `BPT_ADDR_BYTE;
      9'h001: cur = `BPT_TYPE_BYTE;
      9'h002: cur = code[7:0];
      9'h003: cur = code[15:8];
      9'h004: cur = len;
      default: begin
        if (s_reg.bidx == crc_pos) begin
          cur = s_reg.crc[7:0];
        end else if (s_reg.bidx > crc_pos) begin
          cur = s_reg.crc[15:8];
        end else if (s_reg.kind == bpt_pkg::KIND_IMU) begin
          if (p < `BPT_IMU_ADDR_POS) begin
            cur = p[0] ? s_reg.iw[p[4:1]][15:8] : s_reg.iw[p[4:1]][7:0];
          end else if (p == `BPT_IMU_ADDR_POS) begin
            cur = s_reg.iaddr;
          end else if (p >= `BPT_IMU_TS_POS && p < `BPT_IMU_FLAG_POS) begin
            cur = s_reg.its[8 * p[1:0] +: 8];
          end else if (p == `BPT_IMU_FLAG_POS) begin
            cur = {5'h00, s_reg.ina};
          end
        end else if (s_reg.bidx == `BPT_HDR_LEN) begin
          cur = {3'h0, s_reg.nb};
        end else if (s_reg.rb == 4'h0) begin
          cur = bcn_addr_i;
        end else if (s_reg.kind == bpt_pkg::KIND_CM) begin
          case (s_reg.rb)
            4'h1: cur = bcn_x_i[7:0];
            4'h2: cur = bcn_x_i[15:8];
            4'h3: cur = bcn_y_i[7:0];
            4'h4: cur = bcn_y_i[15:8];
            4'h5: cur = bcn_z_i[7:0];
            4'h6: cur = bcn_z_i[15:8];
            default: cur = 8'h00;
          endcase
        end else if (s_reg.rb == `BPT_MM_FLAG_POS) begin
          cur = {7'h00, bcn_na_i};
        end else if (s_reg.rb < 4'h5) begin
          cur = bcn_x_i[8 * 2'(s_reg.rb - 4'h1) +: 8];
        end else if (s_reg.rb < 4'h9) begin
          cur = bcn_y_i[8 * 2'(s_reg.rb - 4'h5) +: 8];
        end else begin
          cur = bcn_z_i[8 * 2'(s_reg.rb - 4'h9) +: 8];
        end
      end
    endcase
  end

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    imu_ok = is_modem_i ? imu_fwd_en_i : raw_imu_en_i;
    // timer for periodic resend while the map stays frozen
    s_next.frozen_d = map_frozen_i;
    if (!map_frozen_i) begin
      s_next.timer = 32'h0;
    end else if (s_reg.timer == 32'(RESEND_CYC - 1)) begin
      s_next.timer = 32'h0;
    end else begin
      s_next.timer = s_reg.timer + 32'h1;
    end
    case (s_reg.st)
      bpt_pkg::TX_IDLE: begin
        s_next.txd = 1'b1;
        s_next.bidx = 9'h0;
        s_next.rec = 5'h0;
        s_next.rb = 4'h0;
        s_next.crc = `BPT_CRC_INIT;
        if (s_reg.imu_pend) begin
          s_next.kind = bpt_pkg::KIND_IMU;
          s_next.imu_pend = 1'b0;
          s_next.st = bpt_pkg::TX_LOAD;
        end else if (s_reg.pos_pend) begin
          s_next.kind = mm_mode_i ? bpt_pkg::KIND_MM : bpt_pkg::KIND_CM;
          // list longer than the length byte can hold is clipped
          s_next.nb = (bcn_count_i > 5'(MAX_BCN)) ? 5'(MAX_BCN) : bcn_count_i;
          s_next.pos_pend = 1'b0;
          s_next.st = bpt_pkg::TX_LOAD;
        end
      end
      bpt_pkg::TX_LOAD: begin
        s_next.txd = 1'b0;
        s_next.shreg = {1'b1, cur};
        s_next.bitcnt = 4'h0;
        s_next.baud = 16'h0;
        if (s_reg.bidx < crc_pos) begin
          s_next.crc = bpt_pkg::bpt_crc_step(s_reg.crc, cur);
        end
        s_next.st = bpt_pkg::TX_SHIFT;
      end
      bpt_pkg::TX_SHIFT: begin
        if (s_reg.baud != 16'(CLKS_PER_BIT - 1)) begin
          s_next.baud = s_reg.baud + 16'h1;
        end else begin
          s_next.baud = 16'h0;
          if (s_reg.bitcnt != 4'h9) begin
            s_next.txd = s_reg.shreg[0];
            s_next.shreg = s_reg.shreg >> 1;
            s_next.bitcnt = s_reg.bitcnt + 4'h1;
          end else begin
            s_next.bidx = s_reg.bidx + 9'h1;
            if (s_reg.kind != bpt_pkg::KIND_IMU && s_reg.bidx > `BPT_HDR_LEN
                && s_reg.bidx < crc_pos) begin
              if (s_reg.rb == rec_len - 4'h1) begin
                s_next.rb = 4'h0;
                s_next.rec = s_reg.rec + 5'h1;
              end else begin
                s_next.rb = s_reg.rb + 4'h1;
              end
            end
            s_next.st = (s_reg.bidx > crc_pos) ? bpt_pkg::TX_IDLE : bpt_pkg::TX_LOAD;
          end
        end
      end
      default: s_next.st = bpt_pkg::TX_IDLE;
    endcase
    // new events are taken after the start clears, so they win
    if (map_frozen_i && (!s_reg.frozen_d || s_reg.timer == 32'(RESEND_CYC - 1))) begin
      s_next.pos_pend = 1'b1;
    end
    // a sample arriving while its own packet is on the line is dropped
    if (imu_valid_i && imu_ok
        && !(s_reg.st != bpt_pkg::TX_IDLE && s_reg.kind == bpt_pkg::KIND_IMU)) begin
      s_next.imu_pend = 1'b1;
      s_next.iw = imu_word_i;
      s_next.iaddr = imu_addr_i;
      s_next.its = imu_ts_i;
      s_next.ina = imu_na_i;
    end
    // busy is registered so the port comes straight from a flop
    s_next.busy = (s_next.st != bpt_pkg::TX_IDLE);
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_reg <= '{st: bpt_pkg::TX_IDLE, kind: bpt_pkg::KIND_CM, crc: `BPT_CRC_INIT,
                 txd: 1'b1, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.line = s_reg.txd;
  assign bcn_sel_o = s_reg.rec;
  assign busy_o = s_reg.busy;
endmodule
`default_nettype wire

// ### bpt_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "bpt_cfg.svh"
module bpt_host #(
  parameter int CLKS_PER_BIT = `BPT_CLKS_PER_BIT,
  parameter int BUF_BYTES = `BPT_BUF_BYTES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // serial link
  bpt_link_if.host link,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // events
  output logic pkt_ok_o,
  output logic pkt_bad_o
);
  typedef struct packed {
    bpt_pkg::bpt_rx_st_t st;
    logic [15:0] baud;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic [8:0] bidx;
    logic [7:0] len;
    logic [15:0] code;
    logic [15:0] crc;
    logic [7:0] crc_lo;
    logic [3:0] rb;
    logic [4:0] na_tmp;
    logic [4:0] na_last;
    logic [15:0] last_code;
    logic [7:0] last_len;
    logic [15:0] good;
    logic [15:0] bad;
    logic en;
    logic [BUF_BYTES-1:0][7:0] buff;
    logic [31:0] rdata;
    logic rdy;
    logic err;
    logic ok;
    logic nok;
  } host_state_t;

  host_state_t s_reg, s_next;
  logic [7:0] b;
  logic [11:0] bi;

  always_comb begin
    s_next = s_reg;
    s_next.ok = 1'b0;
    s_next.nok = 1'b0;
    b = s_reg.sh;
    // ----------------------------------------
    // receiver, sampling mid-bit
    // ----------------------------------------
    case (s_reg.st)
      bpt_pkg::RX_IDLE: begin
        s_next.baud = 16'h0;
        if (!link.line && s_reg.en) begin
          s_next.st = bpt_pkg::RX_START;
        end
      end
      bpt_pkg::RX_START: begin
        s_next.baud = s_reg.baud + 16'h1;
        if (s_reg.baud == 16'(CLKS_PER_BIT / 2)) begin
          s_next.baud = 16'h0;
          s_next.bitcnt = 4'h0;
          s_next.st = link.line ? bpt_pkg::RX_IDLE : bpt_pkg::RX_DATA;
        end
      end
      bpt_pkg::RX_DATA: begin
        s_next.baud = s_reg.baud + 16'h1;
        if (s_reg.baud == 16'(CLKS_PER_BIT - 1)) begin
          s_next.baud = 16'h0;
          s_next.bitcnt = s_reg.bitcnt + 4'h1;
          if (s_reg.bitcnt != 4'h8) begin
            s_next.sh = {link.line, s_reg.sh[7:1]};
          end else begin
            s_next.st = bpt_pkg::RX_IDLE;
            // ----------------------------------------
            // frame parser, one byte per stop bit
            // ----------------------------------------
            if (link.line) begin
              s_next.bidx = s_reg.bidx + 9'h1;
              if (s_reg.bidx < 9'(BUF_BYTES)) begin
                s_next.buff[s_reg.bidx[5:0]] = b;
              end
              if (s_reg.bidx < 9'h2 || s_reg.bidx < 9'(`BPT_HDR_LEN + s_reg.len)) begin
                s_next.crc = bpt_pkg::bpt_crc_step(s_reg.crc, b);
              end
              case (s_reg.bidx)
                9'h000: if (b != `BPT_ADDR_BYTE) s_next.bidx = 9'h0;
                9'h001: if (b != `BPT_TYPE_BYTE) s_next.bidx = 9'h0;
                9'h002: s_next.code[7:0] = b;
                9'h003: s_next.code[15:8] = b;
                9'h004: s_next.len = b;
                default: begin
                  if (s_reg.bidx == 9'(`BPT_HDR_LEN + s_reg.len)) begin
                    s_next.crc_lo = b;
                  end else if (s_reg.bidx > 9'(`BPT_HDR_LEN + s_reg.len)) begin
                    s_next.bidx = 9'h0;
                    if ({b, s_reg.crc_lo} == s_reg.crc) begin
                      s_next.ok = 1'b1;
                      s_next.good = s_reg.good + 16'h1;
                      s_next.last_code = s_reg.code;
                      s_next.last_len = s_reg.len;
                      s_next.na_last = s_reg.na_tmp;
                    end else begin
                      s_next.nok = 1'b1;
                      s_next.bad = s_reg.bad + 16'h1;
                    end
                  end else if (s_reg.code == `BPT_CODE_MM && s_reg.bidx > `BPT_HDR_LEN) begin
                    s_next.rb = (s_reg.rb == `BPT_REC_MM - 4'h1) ? 4'h0 : s_reg.rb + 4'h1;
                    if (s_reg.rb == `BPT_MM_FLAG_POS && b[0]) begin
                      s_next.na_tmp = s_reg.na_tmp + 5'h1;
                    end
                  end
                end
              endcase
              if (s_reg.bidx == 9'h0) begin
                s_next.crc = bpt_pkg::bpt_crc_step(`BPT_CRC_INIT, b);
                s_next.rb = 4'h0;
                s_next.na_tmp = 5'h0;
              end
            end
          end
        end
      end
      default: s_next.st = bpt_pkg::RX_IDLE;
    endcase
    // ----------------------------------------
    // apb, one wait state so data leave a flop
    // ----------------------------------------
    bi = 12'(paddr_i - `BPT_REG_BUF) >> 2;
    s_next.rdy = 1'b0;
    if (psel_i && penable_i && !s_reg.rdy) begin
      s_next.rdy = 1'b1;
      s_next.err = 1'b0;
      s_next.rdata = 32'h0;
      case (paddr_i)
        `BPT_REG_CTRL: s_next.rdata = {31'h0, s_reg.en};
        `BPT_REG_STATUS: s_next.rdata = {8'h00, s_reg.last_len, s_reg.last_code};
        `BPT_REG_COUNT: s_next.rdata = {s_reg.bad, s_reg.good};
        `BPT_REG_NA: s_next.rdata = {27'h0, s_reg.na_last};
        default: begin
          if (paddr_i >= `BPT_REG_BUF && bi < 12'(BUF_BYTES) && paddr_i[1:0] == 2'b00) begin
            s_next.rdata = {24'h0, s_reg.buff[bi[5:0]]};
          end else begin
            s_next.err = 1'b1;
          end
        end
      endcase
      if (paddr_i == `BPT_REG_STATUS || paddr_i == `BPT_REG_COUNT || paddr_i == `BPT_REG_NA) begin
        s_next.err = pwrite_i;
      end
    end
    if (psel_i && penable_i && s_reg.rdy && pwrite_i && !s_reg.err
        && paddr_i == `BPT_REG_CTRL) begin
      s_next.en = pwdata_i[`BPT_CTRL_EN];
      // counters restart; an outcome in the same cycle still counts
      if (pwdata_i[`BPT_CTRL_CLR]) begin
        s_next.good = {15'h0, s_next.ok};
        s_next.bad = {15'h0, s_next.nok};
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_reg <= '{st: bpt_pkg::RX_IDLE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata_o = s_reg.rdata;
  assign pready_o = s_reg.rdy;
  assign pslverr_o = s_reg.err;
  assign pkt_ok_o = s_reg.ok;
  assign pkt_bad_o = s_reg.nok;
endmodule
`default_nettype wire

// ### bpt_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bpt_link_if;
  // idle-high serial line, 8n1
  logic line;
  modport dev (output line);
  modport host (input line);
endinterface
`default_nettype wire

// ### bpt_pkg.sv
`include "bpt_cfg.svh"
`default_nettype none
package bpt_pkg;
  typedef enum logic [1:0] {KIND_CM, KIND_MM, KIND_IMU} bpt_kind_t;
  typedef enum {TX_IDLE, TX_LOAD, TX_SHIFT} bpt_tx_st_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA} bpt_rx_st_t;

  // reflected crc-16, one byte, lsb first
  function automatic logic [15:0] bpt_crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `BPT_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "bpt_cfg.svh"
module tb;
  localparam int CPB = 8;
  localparam int RESEND = 6000;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic map_frozen_i = 1'b0, mm_mode_i = 1'b0, is_modem_i = 1'b0, raw_imu_en_i = 1'b0;
  logic imu_fwd_en_i = 1'b0, imu_valid_i = 1'b0, busy_o, bcn_na_i, err;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic pready_o, pslverr_o, pkt_ok_o, pkt_bad_o, pkt_ok2, pkt_bad2;
  logic [4:0] bcn_count_i = 5'h00, bcn_sel_o;
  logic [8:0][15:0] imu_word_i = '0;
  logic [7:0] imu_addr_i = 8'h00, bcn_addr_i, rb;
  logic [31:0] imu_ts_i = 32'h0, pwdata_i = 32'h0, prdata_o, prdata2, rd, rd2;
  logic [31:0] bcn_x_i, bcn_y_i, bcn_z_i;
  logic [11:0] paddr_i = 12'h000;
  logic [2:0] imu_na_i = 3'h0;
  logic [23:0] base[3] = '{24'h876543, 24'h123456, 24'hfedcba};
  logic [7:0] rx_q[$], exp_q[$];
  int fails = 0, n_tests = 0;
  int ok2 = 0, bad2 = 0;
  bpt_link_if link();
  bpt_link_if link2();
  always #12.5 clock_i = ~clock_i;
  // verdict pulses of the second receiver are one cycle wide, so count them
  always @(posedge clock_i) begin
    if (pkt_ok2 === 1'b1) ok2++;
    if (pkt_bad2 === 1'b1) bad2++;
  end
  // beacon table: odd beacons are marked not applicable
  assign bcn_addr_i = {3'h5, bcn_sel_o};
  assign bcn_x_i = {base[0], 3'h0, bcn_sel_o};
  assign bcn_y_i = {base[1], 3'h1, bcn_sel_o};
  assign bcn_z_i = {base[2], 3'h2, bcn_sel_o};
  assign bcn_na_i = bcn_sel_o[0];
  bpt_dev #(.CLKS_PER_BIT(CPB), .RESEND_CYC(RESEND)) bpt_dev_inst (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .link(link), .map_frozen_i(map_frozen_i), .mm_mode_i(mm_mode_i),
    .bcn_count_i(bcn_count_i), .bcn_sel_o(bcn_sel_o), .bcn_addr_i(bcn_addr_i),
    .bcn_x_i(bcn_x_i), .bcn_y_i(bcn_y_i), .bcn_z_i(bcn_z_i), .bcn_na_i(bcn_na_i),
    .is_modem_i(is_modem_i), .raw_imu_en_i(raw_imu_en_i), .imu_fwd_en_i(imu_fwd_en_i),
    .imu_valid_i(imu_valid_i), .imu_word_i(imu_word_i), .imu_addr_i(imu_addr_i),
    .imu_ts_i(imu_ts_i), .imu_na_i(imu_na_i), .busy_o(busy_o));
  bpt_host #(.CLKS_PER_BIT(CPB)) bpt_host_inst (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .link(link), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .pkt_ok_o(pkt_ok_o), .pkt_bad_o(pkt_bad_o));
  // second receiver shares the apb bus and hears only the bench's faulty frames
  bpt_host #(.CLKS_PER_BIT(CPB)) bpt_host_inst2 (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .link(link2), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata2), .pready_o(),
    .pslverr_o(), .pkt_ok_o(pkt_ok2), .pkt_bad_o(pkt_bad2));
  bpt_asserts bpt_asserts_inst (.clock_i(clock_i), .arst_n_i(arst_n_i), .line(link.line),
    .busy_o(busy_o), .imu_valid_i(imu_valid_i), .is_modem_i(is_modem_i),
    .raw_imu_en_i(raw_imu_en_i), .imu_fwd_en_i(imu_fwd_en_i), .psel_i(psel_i),
    .penable_i(penable_i), .pready_o(pready_o), .pkt_ok_o(pkt_ok_o), .pkt_bad_o(pkt_bad_o));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    rd2 = prdata2;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic put(input logic [31:0] v, input int nb);
    for (int i = 0; i < nb; i++) exp_q.push_back(v[8*i +: 8]);
  endtask
  task automatic seal();
    logic [15:0] c;
    c = `BPT_CRC_INIT;
    foreach (exp_q[i]) begin
      c ^= {8'h00, exp_q[i]};
      for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ `BPT_CRC_POLY : c >> 1;
    end
    put({16'h0000, c}, 2);
  endtask
  task automatic imu_exp();
    put(32'h0347ff, 4);
    put(32'h20, 1);
    for (int k = 0; k < 9; k++) put({16'h0000, imu_word_i[k]}, 2);
    put({24'h0, imu_addr_i}, 1);
    put(32'h0, 4);
    put(32'h0, 1);
    put(imu_ts_i, 4);
    put({29'h0, imu_na_i}, 4);
    seal();
  endtask
  task automatic pos_exp(input logic mm, input int n);
    put(mm ? 32'h1247ff : 32'h0247ff, 4);
    put(32'(1 + n * (mm ? 14 : 8)), 1);
    put(32'(n), 1);
    for (int i = 0; i < n; i++) begin
      put({27'h5, 5'(i)}, 1);
      for (int j = 0; j < 3; j++) put({base[j], 3'(j), 5'(i)}, mm ? 4 : 2);
      put({31'h0, mm & i[0]}, 1);
    end
    seal();
  endtask
  task automatic cmp_pkt();
    while (rx_q.size() < exp_q.size() || busy_o !== 1'b0) begin
      @(posedge clock_i);
    end
    chk(rx_q.size(), exp_q.size());
    foreach (exp_q[i]) chk(rx_q[i], exp_q[i]);
    rx_q.delete();
    exp_q.delete();
    repeat (4) @(posedge clock_i);
  endtask
  // ----------------------------------------
  // line receiver and tests
  // ----------------------------------------
  always begin
    @(negedge link.line);
    repeat (CPB / 2) @(posedge clock_i);
    for (int i = 0; i < 8; i++) begin
      repeat (CPB) @(posedge clock_i);
      rb[i] = link.line;
    end
    repeat (CPB) @(posedge clock_i);
    chk(link.line, 1'b1);
    rx_q.push_back(rb);
  end
  initial begin
    repeat (90000) @(posedge clock_i);
    fails++;
    complete_run();
  end
  initial begin
    int k;
    logic [9:0] fr;
    link2.line = 1'b1;
    repeat (6) @(posedge clock_i);
    arst_n_i <= 1'b1;
    @(posedge clock_i);
    chk(link.line, 1'b1);
    chk(busy_o, 1'b0);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, 12'h000, 32'h1);
    for (int e = 0; e < 4; e++) begin
      @(posedge clock_i);
      is_modem_i <= e[1];
      raw_imu_en_i <= ~e[0];
      imu_fwd_en_i <= e[0];
      imu_ts_i <= 32'h8000_0100 + 32'(e);
      imu_na_i <= 3'(e * 3);
      imu_addr_i <= 8'h30 + 8'(e);
      for (int w = 0; w < 9; w++) imu_word_i[w] <= {4'(w), 4'(e), 8'hc5};
      @(posedge clock_i);
      imu_valid_i <= 1'b1;
      @(posedge clock_i);
      imu_valid_i <= 1'b0;
      if (e[0] == e[1]) begin
        imu_exp();
        cmp_pkt();
      end else begin
        repeat (20) @(posedge clock_i);
        chk(busy_o, 1'b0);
      end
    end
    for (int p = 0; p < 3; p++) begin
      @(posedge clock_i);
      mm_mode_i <= p[0];
      bcn_count_i <= (p == 2) ? 5'h00 : 5'(p + 2);
      map_frozen_i <= 1'b1;
      @(posedge clock_i);
      map_frozen_i <= 1'b0;
      pos_exp(p[0], (p == 2) ? 0 : p + 2);
      cmp_pkt();
      if (p == 1) begin
        apb(1'b0, 12'h00c, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h002b_0012);
        apb(1'b0, 12'h108, 32'h0);
        chk(rd, 32'h0000_0012);
      end
    end
    @(posedge clock_i);
    mm_mode_i <= 1'b0;
    bcn_count_i <= 5'h01;
    map_frozen_i <= 1'b1;
    pos_exp(1'b0, 1);
    cmp_pkt();
    k = 0;
    while (busy_o !== 1'b1 && k < RESEND + 100) begin
      @(posedge clock_i);
      k++;
    end
    chk(32'(k inside {[RESEND - 1400:RESEND + 10]}), 32'h1);
    pos_exp(1'b0, 1);
    cmp_pkt();
    map_frozen_i <= 1'b0;
    repeat (RESEND + 200) @(posedge clock_i);
    chk(rx_q.size(), 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0000_0007);
    imu_exp();
    exp_q[exp_q.size() - 1] ^= 8'h01;
    foreach (exp_q[i]) begin
      fr = {1'b1, exp_q[i], 1'b0};
      for (int j = 0; j < 10; j++) begin
        link2.line <= fr[j];
        repeat (CPB) @(posedge clock_i);
      end
    end
    exp_q.delete();
    apb(1'b0, 12'h008, 32'h0);
    chk(rd2, 32'h0001_0000);
    chk(bad2, 32'h1);
    chk(ok2, 32'h0);
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0);
    chk(rd2, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
